/* hw/osc_pkg.sv */
// Constants, register map and types of the oscillator source control block.
// Assumes a single 40 MHz system clock and a 32-bit AXI4-Lite register bus.
package osc_pkg;
	localparam int CLK_HZ = 40_000_000;
	localparam int CLK_PERIOD_NS = 25;

	// Register bus
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_OSC_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
	localparam logic [7:0] ADDR_CLOCK_STATUS = 8'h0C;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Oscillator control fields
	localparam int SYS_CLK_SEL_BIT = 0;
	localparam int SLOW_STABLE_BIT = 1;
	localparam int FAST_STABLE_BIT = 2;
	localparam int EXT_RUNNING_BIT = 3;
	localparam int FREQ_SEL_LSB = 4;
	localparam int FREQ_SEL_MSB = 6;
	localparam logic [2:0] FREQ_SEL_RESET = 3'h6;
	localparam logic [2:0] FREQ_SEL_SLOW = 3'h0;
	localparam logic SYS_CLK_SEL_RESET = 1'b0;

	// Interrupt status and mask layout
	localparam int IRQ_W = 4;
	localparam int IRQ_OST_DONE = 0;
	localparam int IRQ_FAST_STABLE = 1;
	localparam int IRQ_SLOW_STABLE = 2;
	localparam int IRQ_SWITCH_DONE = 3;
	localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

	// Timing
	localparam int OST_OSC_COUNT = 1024;
	localparam int SWITCH_DELAY_NS = 1000;
	localparam int SWITCH_CYCLES = (SWITCH_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SWITCH_CNT_W = 6;

	// Oscillator amplifier gain
	localparam logic [1:0] GAIN_OFF = 2'h0;
	localparam logic [1:0] GAIN_LOW = 2'h1;
	localparam logic [1:0] GAIN_MEDIUM = 2'h2;
	localparam logic [1:0] GAIN_HIGH = 2'h3;

	typedef enum logic [2:0] {
		MODE_EXT_CLOCK, MODE_LOW_GAIN_XTAL, MODE_MED_GAIN_XTAL, MODE_HIGH_GAIN_XTAL,
		MODE_RC_CLKOUT, MODE_RC_IO, MODE_INT_CLKOUT, MODE_INT_IO
	} osc_mode_type;

	// Core enable period in system clocks for each frequency select code
	function automatic logic [11:0] osc_freq_period(input logic [2:0] code);
		case (code)
			3'h7: osc_freq_period = 12'(CLK_HZ / 8_000_000);
			3'h6: osc_freq_period = 12'(CLK_HZ / 4_000_000);
			3'h5: osc_freq_period = 12'(CLK_HZ / 2_000_000);
			3'h4: osc_freq_period = 12'(CLK_HZ / 1_000_000);
			3'h3: osc_freq_period = 12'(CLK_HZ / 500_000);
			3'h2: osc_freq_period = 12'(CLK_HZ / 250_000);
			3'h1: osc_freq_period = 12'(CLK_HZ / 125_000);
			default: osc_freq_period = 12'(CLK_HZ / 31_000);
		endcase
	endfunction
endpackage

/* hw/osc_ctrl.sv */
// Oscillator source control: register, start-up timer, source switching, core enable.
// Assumes one 40 MHz clock, AXI4-Lite master, fuse config inputs stable, analog ready levels.
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
module osc_ctrl
	import osc_pkg::*;
#(
	parameter int OST_OSC = osc_pkg::OST_OSC_COUNT
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [osc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [osc_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [2:0] device_config_word_mode,
	input wire logic two_speed_enable,
	input wire logic fail_safe_enable,
	input wire logic power_up_timer_enable,
	input wire logic power_up_timer_expired,
	input wire logic sleep_request,
	input wire logic wake_event,
	input wire logic crystal_in_pin,
	input wire logic fast_osc_ready_pin,
	input wire logic slow_osc_ready_pin,
	output logic core_clk_en,
	output logic sys_clk_external,
	output logic [1:0] amp_gain,
	output logic crystal_out_gpio_free,
	output logic fast_osc_enable,
	output logic slow_osc_enable,
	output logic irq
);
	import osc_pkg::*;

	if (OST_OSC < 1 || OST_OSC > 2047) begin : g_bad_ost
		$error("OST_OSC must lie between 1 and 2047");
	end

	typedef enum logic [2:0] {
		SEQ_POWER_UP, SEQ_OST, SEQ_SWITCH, SEQ_RUN, SEQ_SLEEP
	} osc_seq_type;

	typedef struct packed {
		osc_seq_type seq;
		logic [2:0] freq_sel;
		logic sys_clk_sel;
		logic ext_running;
		logic hold_zero;
		logic ost_done;
		logic [10:0] ost_cnt;
		logic [SWITCH_CNT_W-1:0] sw_cnt;
		logic [11:0] div_cnt;
		logic [2:0] xin_sync;
		logic [1:0] fast_sync;
		logic [1:0] slow_sync;
		logic fast_prev;
		logic slow_prev;
		logic src_ext;
		logic src_slow;
		logic core_clk_en;
		logic [1:0] amp_gain;
		logic out_gpio;
		logic fast_en;
		logic slow_en;
		logic [IRQ_W-1:0] irq_status;
		logic [IRQ_W-1:0] irq_mask;
		logic irq;
		logic aw_held;
		logic w_held;
		logic [ADDR_W-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} osc_state_type;

	osc_state_type s;
	osc_state_type n;

	function automatic logic mode_is_xtal(input logic [2:0] mode);
		mode_is_xtal = (mode == MODE_LOW_GAIN_XTAL) || (mode == MODE_MED_GAIN_XTAL) ||
			(mode == MODE_HIGH_GAIN_XTAL);
	endfunction

	function automatic logic mode_is_external(input logic [2:0] mode);
		mode_is_external = (mode != MODE_INT_CLKOUT) && (mode != MODE_INT_IO);
	endfunction

	function automatic logic [ADDR_W-1:0] word_addr(input logic [ADDR_W-1:0] addr);
		word_addr = {addr[ADDR_W-1:2], 2'b00};
	endfunction

	logic xin_rise;
	logic fast_stable;
	logic slow_stable;
	logic want_ext;
	logic want_slow;
	logic src_change;
	logic [IRQ_W-1:0] events;
	logic [IRQ_W-1:0] rd_clear;
	logic [7:0] osc_control_view;
	logic [ADDR_W-1:0] wa;
	logic [ADDR_W-1:0] ra;

	always_comb begin
		n = s;
		events = '0;
		rd_clear = '0;
		wa = word_addr(s.awaddr);
		ra = word_addr(s_axi_araddr);

		// Crystal input and analog ready levels cross into the system clock
		n.xin_sync = {s.xin_sync[1], s.xin_sync[0], crystal_in_pin};
		n.fast_sync = {s.fast_sync[0], fast_osc_ready_pin};
		n.slow_sync = {s.slow_sync[0], slow_osc_ready_pin};
		xin_rise = s.xin_sync[1] & ~s.xin_sync[2];
		fast_stable = s.fast_sync[1];
		slow_stable = s.slow_sync[1];
		n.fast_prev = fast_stable;
		n.slow_prev = slow_stable;
		events[IRQ_FAST_STABLE] = fast_stable & ~s.fast_prev;
		events[IRQ_SLOW_STABLE] = slow_stable & ~s.slow_prev;

		// Wanted source from select bit, frequency select and config mode
		want_ext = !s.sys_clk_sel && mode_is_external(device_config_word_mode);
		want_slow = !want_ext && (s.freq_sel == FREQ_SEL_SLOW);
		src_change = (want_ext != s.src_ext) || (!want_ext && (want_slow != s.src_slow));

		// Core enable pulses from the active source
		n.core_clk_en = 1'b0;
		if (s.seq == SEQ_RUN) begin
			if (s.src_ext) begin
				n.core_clk_en = xin_rise;
			end else if (s.src_slow ? slow_stable : fast_stable) begin
				if (s.div_cnt == 12'h000) begin
					n.core_clk_en = 1'b1;
					n.div_cnt = osc_freq_period(s.freq_sel) - 12'h001;
				end else begin
					n.div_cnt = s.div_cnt - 12'h001;
				end
			end
		end

		// Start-up and switch sequencer
		case (s.seq)
			SEQ_POWER_UP: begin
				if (!power_up_timer_enable || power_up_timer_expired) begin
					n.src_ext = want_ext;
					n.src_slow = want_slow;
					if (want_ext && mode_is_xtal(device_config_word_mode)) begin
						n.seq = SEQ_OST;
						n.ost_cnt = '0;
					end else begin
						n.seq = SEQ_RUN;
						n.ost_done = 1'b1;
					end
				end
			end
			SEQ_OST: begin
				if (xin_rise) begin
					if (s.ost_cnt == 11'(OST_OSC - 1)) begin
						n.ost_done = 1'b1;
						n.seq = SEQ_RUN;
						events[IRQ_OST_DONE] = 1'b1;
					end else begin
						n.ost_cnt = s.ost_cnt + 11'h001;
					end
				end
			end
			SEQ_SWITCH: begin
				if (s.sw_cnt == '0) begin
					n.seq = SEQ_RUN;
					events[IRQ_SWITCH_DONE] = 1'b1;
				end else begin
					n.sw_cnt = s.sw_cnt - SWITCH_CNT_W'(1);
				end
			end
			SEQ_RUN: begin
				if (sleep_request) begin
					n.seq = SEQ_SLEEP;
					if (mode_is_xtal(device_config_word_mode)) begin
						n.ost_done = 1'b0;
					end
				end else if (src_change) begin
					n.src_ext = want_ext;
					n.src_slow = want_slow;
					n.div_cnt = '0;
					if (want_ext && !s.ost_done) begin
						n.seq = SEQ_OST;
						n.ost_cnt = '0;
					end else begin
						n.seq = SEQ_SWITCH;
						n.sw_cnt = SWITCH_CNT_W'(SWITCH_CYCLES - 1);
					end
				end
			end
			SEQ_SLEEP: begin
				if (wake_event) begin
					n.src_ext = want_ext;
					n.src_slow = want_slow;
					n.div_cnt = '0;
					if (want_ext && mode_is_xtal(device_config_word_mode)) begin
						n.seq = SEQ_OST;
						n.ost_cnt = '0;
					end else begin
						n.seq = SEQ_RUN;
						n.ost_done = 1'b1;
					end
				end
			end
			default: begin
				n.seq = SEQ_POWER_UP;
			end
		endcase

		n.ext_running = n.src_ext && (n.ost_done || !s.hold_zero);

		// Pin-facing controls from the config mode, the active source and the fuse enables
		case (device_config_word_mode)
			MODE_LOW_GAIN_XTAL: n.amp_gain = GAIN_LOW;
			MODE_MED_GAIN_XTAL: n.amp_gain = GAIN_MEDIUM;
			MODE_HIGH_GAIN_XTAL: n.amp_gain = GAIN_HIGH;
			default: n.amp_gain = GAIN_OFF;
		endcase
		n.out_gpio = (device_config_word_mode == MODE_EXT_CLOCK) ||
			(device_config_word_mode == MODE_RC_IO) || (device_config_word_mode == MODE_INT_IO);
		n.fast_en = !n.src_ext && !n.src_slow;
		n.slow_en = (!n.src_ext && n.src_slow) || power_up_timer_enable || fail_safe_enable;

		osc_control_view = {1'b0, s.freq_sel, s.ext_running, fast_stable, slow_stable,
			s.sys_clk_sel};

		// Write channel: address and data taken in either order
		if (s_axi_awvalid && s.awready) begin
			n.aw_held = 1'b1;
			n.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s.wready) begin
			n.w_held = 1'b1;
			n.wdata = s_axi_wdata;
			n.wstrb = s_axi_wstrb;
		end
		if (s.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (s.aw_held && s.w_held && !s.bvalid) begin
			n.aw_held = 1'b0;
			n.w_held = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = RESP_OKAY;
			case (wa)
				ADDR_OSC_CONTROL: begin
					if (s.wstrb[0]) begin
						n.freq_sel = s.wdata[FREQ_SEL_MSB:FREQ_SEL_LSB];
						n.sys_clk_sel = s.wdata[SYS_CLK_SEL_BIT];
					end
				end
				ADDR_IRQ_MASK: begin
					if (s.wstrb[0]) begin
						n.irq_mask = s.wdata[IRQ_W-1:0];
					end
				end
				ADDR_IRQ_STATUS, ADDR_CLOCK_STATUS: begin
					n.bresp = RESP_OKAY;
				end
				default: begin
					n.bresp = RESP_SLVERR;
				end
			endcase
		end

		// Read channel
		if (s.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s.arready) begin
			n.rvalid = 1'b1;
			n.rresp = RESP_OKAY;
			n.rdata = '0;
			case (ra)
				ADDR_OSC_CONTROL: n.rdata = {24'h000000, osc_control_view};
				ADDR_IRQ_STATUS: begin
					n.rdata = {28'h0000000, s.irq_status};
					rd_clear = s.irq_status;
				end
				ADDR_IRQ_MASK: n.rdata = {28'h0000000, s.irq_mask};
				ADDR_CLOCK_STATUS: n.rdata = {25'h0000000, s.seq == SEQ_RUN, s.amp_gain,
					s.seq == SEQ_OST, device_config_word_mode};
				default: n.rresp = RESP_SLVERR;
			endcase
		end

		// Sticky events, a new event beats a read clear
		n.irq_status = (s.irq_status & ~rd_clear) | events;
		n.irq = |(n.irq_status & n.irq_mask);
		n.awready = !n.aw_held && !n.bvalid;
		n.wready = !n.w_held && !n.bvalid;
		n.arready = !n.rvalid;

		if (rst) begin
			n = '0;
			n.seq = SEQ_POWER_UP;
			n.freq_sel = FREQ_SEL_RESET;
			n.sys_clk_sel = SYS_CLK_SEL_RESET;
			n.irq_mask = IRQ_MASK_RESET;
			n.bresp = RESP_OKAY;
			n.rresp = RESP_OKAY;
			n.hold_zero = (two_speed_enable && mode_is_xtal(device_config_word_mode)) ||
				fail_safe_enable;
			n.src_ext = mode_is_external(device_config_word_mode);
			n.ext_running = n.src_ext && !n.hold_zero;
		end
	end

	always_ff @(posedge clk_sys) begin
		s <= n;
	end

	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_bresp = s.bresp;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_arready = s.arready;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign s_axi_rvalid = s.rvalid;
	assign core_clk_en = s.core_clk_en;
	assign sys_clk_external = s.src_ext;
	assign amp_gain = s.amp_gain;
	assign crystal_out_gpio_free = s.out_gpio;
	assign fast_osc_enable = s.fast_en;
	assign slow_osc_enable = s.slow_en;
	assign irq = s.irq;
endmodule // osc_ctrl

/* dv/osc_ctrl_properties.sv */
// Port assertions for the oscillator source control block.
// Assumes mode and config levels change only while reset is held.
module osc_ctrl_properties
	import osc_pkg::*;
#(
	parameter int OST_OSC = osc_pkg::OST_OSC_COUNT
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic s_axi_awvalid,
	input wire logic [osc_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic [2:0] device_config_word_mode,
	input wire logic two_speed_enable,
	input wire logic power_up_timer_enable,
	input wire logic sleep_request,
	input wire logic crystal_in_pin,
	input wire logic fast_osc_ready_pin,
	input wire logic slow_osc_ready_pin,
	input wire logic core_clk_en,
	input wire logic sys_clk_external,
	input wire logic [1:0] amp_gain,
	input wire logic crystal_out_gpio_free
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [ADDR_W-1:0] rd_sel;
	logic [11:0] rises;
	logic slept;
	logic wrote;
	wire logic [2:0] md = device_config_word_mode;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// Pin rises since reset, sleep and write history
	always_ff @(posedge clk_sys) begin
		if (s_axi_arvalid && s_axi_arready)
			rd_sel <= s_axi_araddr;
		if (rst) begin
			rises <= 12'h000;
			slept <= 1'b0;
			wrote <= 1'b0;
		end else begin
			if ($rose(crystal_in_pin) && !(&rises))
				rises <= rises + 12'h001;
			if (sleep_request)
				slept <= 1'b1;
			if (s_axi_awvalid)
				wrote <= 1'b1;
		end
	end
	sequence pins_quiet;
		$stable({fast_osc_ready_pin, slow_osc_ready_pin})[*8];
	endsequence
	AST_BIT7_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:7] == 25'h0)
		else $error("read data above bit 6 not zero");
	AST_GAIN: assert property (!$past(rst) |-> amp_gain ==
		(md inside {3'h1, 3'h2, 3'h3} ? md[1:0] : GAIN_OFF))
		else $error("amplifier gain does not follow mode");
	AST_GPIO_FREE: assert property (!$past(rst) && md == 3'h0 |-> crystal_out_gpio_free)
		else $error("crystal output not freed in external clock mode");
	AST_EXT_INTERNAL: assert property (md[2:1] == 2'h3 |-> !sys_clk_external)
		else $error("external source flagged in internal mode");
	AST_EC_STATIC: assert property ($stable(crystal_in_pin)[*8] ##0
		(md == 3'h0 && sys_clk_external) |-> !core_clk_en)
		else $error("core enabled with external clock stopped");
	AST_EC_NO_DELAY: assert property (md == 3'h0 && !wrote && !slept &&
		!power_up_timer_enable && $rose(crystal_in_pin) |-> ##[1:6] core_clk_en)
		else $error("external clock edge gave no core enable");
	AST_XTAL_HOLD: assert property (md inside {3'h1, 3'h2, 3'h3} && !two_speed_enable &&
		!slept && rises < OST_OSC |-> !core_clk_en)
		else $error("core enabled before start-up count done");
	AST_STATUS_PINS: assert property (pins_quiet ##0
		(s_axi_rvalid && rd_sel == ADDR_OSC_CONTROL) |->
		s_axi_rdata[2:1] == {fast_osc_ready_pin, slow_osc_ready_pin})
		else $error("stable bits do not match oscillator readiness");
	COV_CTRL_READ: cover property (s_axi_rvalid && rd_sel == ADDR_OSC_CONTROL);
	COV_XTAL_RUN: cover property (md == 3'h2 && core_clk_en);
	COV_SWITCH: cover property ($fell(sys_clk_external));
endmodule // osc_ctrl_properties

/* dv/osc_xtal_model.sv */
// Crystal or external clock source on the crystal input pin.
// Assumes the bench gates it; the pin stands low while stopped.
module osc_xtal_model #(
	parameter int HALF_NS = 100
) (
	input wire logic run,
	output logic pin
);
	timeunit 1ns;
	timeprecision 1ps;
	initial pin = 1'b0;
	always begin
		#(HALF_NS);
		pin = run ? !pin : 1'b0;
	end
endmodule // osc_xtal_model

/* dv/tb_oscillator_source_control.sv */
// Self-checking bench for the oscillator source control block.
// Assumes the crystal model on the pin and an AXI4-Lite master here.
module tb_oscillator_source_control;
	timeunit 1ns;
	timeprecision 1ps;
	import osc_pkg::*;
	localparam int OSCILLATOR_STARTUP_TIMER = 8;
	logic clk_sys = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, ts = 1'b0, fs = 1'b0, pwe = 1'b0, pwx = 1'b0;
	logic slp = 1'b0, wake = 1'b0, xrun = 1'b0, xpin, fpin = 1'b1, spin = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [2:0] mode = 3'h0;
	logic [1:0] bresp, rresp, gain;
	logic awready, wready, bvalid, arready, rvalid, core, ext, gfree, fen, sen, irq;
	int n_mismatch = 0, checks_done = 0, n_rise = 0;
	int per[8] = '{1290, 320, 160, 80, 40, 20, 10, 5};
	always #12.5 clk_sys = ~clk_sys;
	always @(posedge xpin) n_rise++;
	osc_xtal_model osc_xtal_model_i (.run(xrun), .pin(xpin));
	osc_ctrl #(.OST_OSC(OSCILLATOR_STARTUP_TIMER)) osc_ctrl_i (.clk_sys(clk_sys), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.device_config_word_mode(mode), .two_speed_enable(ts), .fail_safe_enable(fs),
		.power_up_timer_enable(pwe), .power_up_timer_expired(pwx), .sleep_request(slp),
		.wake_event(wake), .crystal_in_pin(xpin), .fast_osc_ready_pin(fpin),
		.slow_osc_ready_pin(spin), .core_clk_en(core), .sys_clk_external(ext),
		.amp_gain(gain), .crystal_out_gpio_free(gfree), .fast_osc_enable(fen),
		.slow_osc_enable(sen), .irq(irq));
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic boot(input logic [2:0] m, input logic t, input logic f);
		@(posedge clk_sys);
		rst <= 1'b1;
		mode <= m;
		ts <= t;
		fs <= f;
		cyc(5);
		rst <= 1'b0;
		cyc(2);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!bvalid);
		chk(32'(bresp), 32'(RESP_OKAY));
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, e);
	endtask
	task automatic wait_core(input int lim, output int n);
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (!core && n < lim);
	endtask
	task automatic t_ext();
		int n;
		logic [31:0] d;
		logic [1:0] r;
		boot(3'h0, 1'b0, 1'b0);
		xrun = 1'b1;
		wait_core(40, n);
		chk(32'(n <= 16), 32'h1);
		rc(ADDR_OSC_CONTROL, 32'h6E);
		chk({29'h0, ext, fen, sen}, 32'h4);
		chk(32'(gfree), 32'h1);
		fpin <= 1'b0;
		spin <= 1'b0;
		cyc(8);
		rc(ADDR_OSC_CONTROL, 32'h68);
		fpin <= 1'b1;
		spin <= 1'b1;
		rd(8'h10, d, r);
		chk(d, 32'h0);
		chk(32'(r), 32'(RESP_SLVERR));
		xrun = 1'b0;
		cyc(20);
		wait_core(60, n);
		chk(32'(n), 32'h3C);
		xrun = 1'b1;
		wait_core(30, n);
		chk(32'(n < 30), 32'h1);
	endtask
	task automatic t_switch();
		int n;
		logic [31:0] d;
		logic [1:0] r;
		wr(ADDR_IRQ_MASK, 8'h08);
		wr(ADDR_OSC_CONTROL, 8'h61);
		cyc(1);
		wait_core(200, n);
		chk(32'(n > 30), 32'h1);
		cyc(2);
		chk(32'(irq), 32'h1);
		rd(ADDR_IRQ_STATUS, d, r);
		chk(d & 32'h8, 32'h8);
		cyc(2);
		chk(32'(irq), 32'h0);
		rc(ADDR_OSC_CONTROL, 32'h67);
		chk({29'h0, ext, fen, sen}, 32'h2);
		for (int c = 7; c >= 0; c--) begin
			wr(ADDR_OSC_CONTROL, {1'b0, 3'(c), 4'h1});
			wait_core(3000, n);
			wait_core(3000, n);
			chk(32'(n), 32'(per[c]));
		end
		chk({29'h0, ext, fen, sen}, 32'h1);
		wr(ADDR_OSC_CONTROL, 8'hFF);
		rc(ADDR_OSC_CONTROL, 32'h77);
		wr(ADDR_OSC_CONTROL, 8'h60);
		cyc(60);
		rc(ADDR_OSC_CONTROL, 32'h6E);
	endtask
	task automatic xtal_boot(input logic [2:0] m);
		int n;
		n_rise = 0;
		xrun = 1'b1;
		wait_core(4000, n);
		chk(32'(n_rise >= OSCILLATOR_STARTUP_TIMER && n_rise <= OSCILLATOR_STARTUP_TIMER + 1), 32'h1);
	endtask
	task automatic t_xtal();
		int n;
		for (int m = 1; m <= 3; m++) begin
			xrun = 1'b0;
			boot(3'(m), 1'b0, 1'b0);
			cyc(2);
			chk(32'(gain), 32'(m));
			chk(32'(gfree), 32'h0);
			rc(ADDR_OSC_CONTROL, 32'h6E);
			xtal_boot(3'(m));
		end
		@(posedge clk_sys);
		slp <= 1'b1;
		@(posedge clk_sys);
		slp <= 1'b0;
		cyc(8);
		wait_core(100, n);
		chk(32'(n), 32'h64);
		wake <= 1'b1;
		@(posedge clk_sys);
		wake <= 1'b0;
		xtal_boot(3'h3);
		xrun = 1'b0;
		boot(3'h1, 1'b1, 1'b0);
		rc(ADDR_OSC_CONTROL, 32'h66);
		boot(3'h2, 1'b0, 1'b1);
		rc(ADDR_OSC_CONTROL, 32'h66);
		pwe <= 1'b1;
		boot(3'h3, 1'b0, 1'b0);
		xrun = 1'b1;
		wait_core(200, n);
		chk(32'(n), 32'hC8);
		pwx <= 1'b1;
		xtal_boot(3'h3);
		pwe <= 1'b0;
		pwx <= 1'b0;
		for (int m = 4; m <= 7; m++) begin
			boot(3'(m), 1'b0, 1'b0);
			rc(ADDR_OSC_CONTROL, m < 6 ? 32'h6E : 32'h66);
			rc(ADDR_CLOCK_STATUS, 32'h40 + 32'(m));
			chk(32'(gfree), 32'(m % 2));
		end
	endtask
	initial begin
		repeat (60000) @(posedge clk_sys);
		n_mismatch++;
		finish_test();
	end
	initial begin
		cyc(1);
		t_ext();
		t_switch();
		t_xtal();
		finish_test();
	end
endmodule // tb_oscillator_source_control
bind osc_ctrl osc_ctrl_properties #(.OST_OSC(OST_OSC)) osc_ctrl_properties_i (.*);
